// [verilog/ycs_pkg.sv]
// Package for the indexed-Y bus-cycle sequencer: opcodes, bus constants,
// cycle groups, bus actions, state codes and carrier structs.
// Assumes one processor clock and a byte-wide system bus.
package ycs_pkg;

	// ==========================================================
	// Opcode bytes
	localparam logic [7:0] PREFIX_PAGE  = 8'h18; // Page-select prefix
	localparam logic [7:0] OP_JUMP      = 8'h6E; // jump_instruction
	localparam logic [7:0] OP_TEST      = 8'h6D; // test_operand_instruction
	localparam logic [7:0] OP_LOAD16    = 8'hEC; // Sixteen-bit load
	localparam logic [7:0] OP_ADD16     = 8'hE3; // add_double_accumulator
	localparam logic [7:0] OP_STORE16   = 8'hED; // store_double_accumulator
	localparam logic [7:0] OP_STOREA    = 8'hA7; // store_accumulator_a

	// ==========================================================
	// Bus constants and timing
	localparam logic [15:0] DUMMY_ADDR  = 16'hFFFF; // Dummy-cycle address
	localparam logic [1:0]  PH_FIRST    = 2'h0;     // First clock of a cycle
	localparam logic [1:0]  PH_LAST     = 2'h3;     // Clocks per bus cycle - 1
	localparam logic [2:0]  CYC_FIRST   = 3'h1;     // Number of first cycle
	localparam logic [2:0]  CYC_IDLE    = 3'h0;     // Cycle number when idle
	localparam logic [15:0] OPERAND_RST = 16'h0000; // Operand after reset

	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		GRP_READ8   = 3'h0,
		GRP_JUMP    = 3'h1,
		GRP_TEST    = 3'h2,
		GRP_READ16  = 3'h3,
		GRP_ARITH16 = 3'h4,
		GRP_STORE16 = 3'h5,
		GRP_STORE8  = 3'h6
	} ycs_grp_t;

	typedef enum logic [2:0] {
		ACT_END    = 3'h0,
		ACT_FETCH  = 3'h1,
		ACT_DUMMY  = 3'h2,
		ACT_RD_EA  = 3'h3,
		ACT_RD_EA1 = 3'h4,
		ACT_WR_HI  = 3'h5,
		ACT_WR_LO  = 3'h6,
		ACT_WR_ACC = 3'h7
	} ycs_act_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUS  = 2'b10
	} ycs_state_t;

	typedef struct packed {
		logic [15:0] opcode_addr; // Address of the prefix byte
		logic [15:0] index_y;     // second_index_register value
		logic [7:0]  acc_a;       // Accumulator A value
		logic [15:0] reg16;       // Sixteen-bit register to store
	} ycs_req_t;

	typedef struct packed {
		logic [15:0] addr;      // Address bus
		logic        rw;        // High read, low write
		logic [7:0]  dout;      // Write data
		logic        dout_oe_b; // Low while data is driven
	} ycs_bus_t;

	localparam ycs_bus_t BUS_IDLE = '{addr: DUMMY_ADDR, rw: 1'b1,
		dout: 8'h00, dout_oe_b: 1'b1};

endpackage

// [verilog/ycs_sequencer.sv]
// Bus-cycle sequencer for indexed-Y instructions of an 8-bit core.
// Assumes memory answers combinationally on bus_din; that input is
// synchronised by two flip-flops, so each bus cycle lasts four clocks.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Cycles 1-3 fetch $18, opcode byte, offset at address +0..+2.
// - Cycle 4 is a dummy read of $FFFF; data ignored, address formed.
// - Jump ($6E) takes 4 cycles, no operand access.
// - Test ($6D): 7 cycles, reads operand, no write, cycle 7 dummy.
// - 16-bit reads: EA cycle 5, EA+1 cycle 6; arithmetic adds dummy 7.
// - 16-bit stores take 6 cycles, write high then low, read/write low.
module ycs_sequencer
	import ycs_pkg::*;
(
	input  wire logic   ref_clk,    // Processor clock, 10 MHz
	input  wire logic   rst_b,      // Asynchronous reset, active low
	input  wire logic   start,      // Pulse: begin an instruction
	input  wire ycs_req_t req,      // Instruction context at start
	input  wire logic [7:0] bus_din, // Data bus from memory
	output ycs_bus_t    bus,        // Address, read/write, write data
	output logic        busy,       // High while an instruction runs
	output logic        done,       // Pulse: instruction finished
	output logic        prefix_err, // First byte was not the prefix
	output ycs_grp_t    group,      // Decoded instruction group
	output logic [15:0] operand     // Operand bytes read
);

	// ==========================================================
	// Registers
	ycs_state_t  state, next_state;
	logic [2:0]  cyc, next_cyc;
	logic [1:0]  ph, next_ph;
	ycs_act_t    act, next_act;
	ycs_req_t    instr, next_instr;
	logic [15:0] ea, next_ea;
	ycs_bus_t    next_bus;
	logic        next_busy;
	logic        next_done;
	logic        next_prefix_err;
	ycs_grp_t    next_group;
	logic [15:0] next_operand;
	logic [7:0]  din_meta;
	logic [7:0]  din_sync;

	// ==========================================================
	// Group decode from the second opcode byte
	function automatic ycs_grp_t decode_grp(input logic [7:0] op);
		ycs_grp_t g;
		g = GRP_READ8;
		if (op == OP_JUMP) begin
			g = GRP_JUMP;
		end else if (op == OP_TEST) begin
			g = GRP_TEST;
		end else if (op == OP_LOAD16) begin
			g = GRP_READ16;
		end else if (op == OP_ADD16) begin
			g = GRP_ARITH16;
		end else if (op == OP_STORE16) begin
			g = GRP_STORE16;
		end else if (op == OP_STOREA) begin
			g = GRP_STORE8;
		end
		return g;
	endfunction

	// Bus action of cycle c for group g
	function automatic ycs_act_t act_for(input ycs_grp_t g,
		input logic [2:0] c);
		ycs_act_t a;
		a = ACT_END;
		unique case (c)
			3'h1, 3'h2, 3'h3: a = ACT_FETCH;
			3'h4: a = ACT_DUMMY;
			3'h5: begin
				if (g == GRP_JUMP) begin
					a = ACT_END;
				end else if (g == GRP_STORE16) begin
					a = ACT_WR_HI;
				end else if (g == GRP_STORE8) begin
					a = ACT_WR_ACC;
				end else begin
					a = ACT_RD_EA;
				end
			end
			3'h6: begin
				if (g == GRP_TEST) begin
					a = ACT_DUMMY;
				end else if (g == GRP_READ16 || g == GRP_ARITH16) begin
					a = ACT_RD_EA1;
				end else if (g == GRP_STORE16) begin
					a = ACT_WR_LO;
				end else begin
					a = ACT_END;
				end
			end
			3'h7: begin
				if (g == GRP_TEST || g == GRP_ARITH16) begin
					a = ACT_DUMMY;
				end else begin
					a = ACT_END;
				end
			end
			default: a = ACT_END;
		endcase
		return a;
	endfunction

	// ==========================================================
	// Data bus synchroniser
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			din_meta <= 8'h00;
			din_sync <= 8'h00;
		end else begin
			din_meta <= bus_din;
			din_sync <= din_meta;
		end
	end

	// ==========================================================
	// Sequencer next-state logic
	always_comb begin
		ycs_act_t   na;
		logic [2:0] cn;
		na              = ACT_END;
		cn              = cyc + 3'h1;
		next_state      = state;
		next_cyc        = cyc;
		next_ph         = ph;
		next_act        = act;
		next_instr      = instr;
		next_ea         = ea;
		next_bus        = bus;
		next_busy       = busy;
		next_done       = 1'b0;
		next_prefix_err = prefix_err;
		next_group      = group;
		next_operand    = operand;
		unique case (state)
			ST_IDLE: begin
				if (start) begin
					// Cycle 1: prefix fetch at the opcode address
					next_state      = ST_BUS;
					next_instr      = req;
					next_cyc        = CYC_FIRST;
					next_ph         = PH_FIRST;
					next_act        = ACT_FETCH;
					next_busy       = 1'b1;
					next_prefix_err = 1'b0;
					next_bus        = BUS_IDLE;
					next_bus.addr   = req.opcode_addr;
				end
			end
			ST_BUS: begin
				if (ph != PH_LAST) begin
					next_ph = ph + 2'h1;
				end else begin
					next_ph = PH_FIRST;
					// Use the byte read in the closing cycle
					unique case (cyc)
						3'h1: next_prefix_err = (din_sync != PREFIX_PAGE);
						3'h2: next_group = decode_grp(din_sync);
						3'h3: next_ea = instr.index_y + {8'h00, din_sync};
						default: begin
							if (act == ACT_RD_EA) begin
								next_operand = {8'h00, din_sync};
							end else if (act == ACT_RD_EA1) begin
								next_operand = {operand[7:0], din_sync};
							end
						end
					endcase
					// Choose the following bus cycle
					na       = act_for(group, cn);
					next_act = na;
					next_cyc = cn;
					next_bus = BUS_IDLE;
					unique case (na)
						ACT_FETCH: next_bus.addr = instr.opcode_addr
							+ {13'h0000, cn - 3'h1};
						ACT_DUMMY: next_bus.addr = DUMMY_ADDR;
						ACT_RD_EA: next_bus.addr = ea;
						ACT_RD_EA1: next_bus.addr = ea + 16'h0001;
						ACT_WR_HI: begin
							next_bus.addr      = ea;
							next_bus.rw        = 1'b0;
							next_bus.dout      = instr.reg16[15:8];
							next_bus.dout_oe_b = 1'b0;
						end
						ACT_WR_LO: begin
							next_bus.addr      = ea + 16'h0001;
							next_bus.rw        = 1'b0;
							next_bus.dout      = instr.reg16[7:0];
							next_bus.dout_oe_b = 1'b0;
						end
						ACT_WR_ACC: begin
							next_bus.addr      = ea;
							next_bus.rw        = 1'b0;
							next_bus.dout      = instr.acc_a;
							next_bus.dout_oe_b = 1'b0;
						end
						ACT_END: begin
							// Instruction over; bus returns to idle read
							next_state = ST_IDLE;
							next_cyc   = CYC_IDLE;
							next_busy  = 1'b0;
							next_done  = 1'b1;
						end
					endcase
				end
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ST_IDLE;
			cyc        <= CYC_IDLE;
			ph         <= PH_FIRST;
			act        <= ACT_END;
			instr      <= '0;
			ea         <= 16'h0000;
			bus        <= BUS_IDLE;
			busy       <= 1'b0;
			done       <= 1'b0;
			prefix_err <= 1'b0;
			group      <= GRP_READ8;
			operand    <= OPERAND_RST;
		end else begin
			state      <= next_state;
			cyc        <= next_cyc;
			ph         <= next_ph;
			act        <= next_act;
			instr      <= next_instr;
			ea         <= next_ea;
			bus        <= next_bus;
			busy       <= next_busy;
			done       <= next_done;
			prefix_err <= next_prefix_err;
			group      <= next_group;
			operand    <= next_operand;
		end
	end

endmodule

`default_nettype wire

// [sim/ycs_sequencer_asserts.sv]
// Checker for the indexed-Y bus-cycle sequencer.
// Sees only the sequencer's ports; bound to it below.
`timescale 1ns/1ps
`default_nettype none
module ycs_sequencer_asserts
	import ycs_pkg::*;
(
	input wire logic        ref_clk,    // Clock
	input wire logic        rst_b,      // Reset, active low
	input wire logic        start,      // Start pulse
	input wire ycs_req_t    req,        // Request
	input wire logic [7:0]  bus_din,    // Read data
	input wire ycs_bus_t    bus,        // Bus
	input wire logic        busy,       // Busy
	input wire logic        done,       // Done
	input wire logic        prefix_err, // Prefix flag
	input wire ycs_grp_t    group,      // Group
	input wire logic [15:0] operand     // Operand
);
	// ==========================================================
	// Clocks since the taking edge, request held
	logic [5:0] cnt;
	ycs_req_t   rq;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= 6'h00;
			rq  <= '0;
		end else if (start && !busy) begin
			cnt <= 6'h01;
			rq  <= req;
		end else if (busy) begin
			cnt <= cnt + 6'h01;
		end
	end

	// Bus cycles of each group
	function automatic int ncyc(ycs_grp_t g);
		case (g)
			GRP_JUMP:                return 4;
			GRP_TEST, GRP_ARITH16:   return 7;
			GRP_READ16, GRP_STORE16: return 6;
			default:                 return 5;
		endcase
	endfunction

	// ==========================================================
	// Properties
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	property p_fetch;
		start && !busy |=> bus.addr == $past(req.opcode_addr) && bus.rw
			##4 bus.addr == rq.opcode_addr + 16'h0001
			##4 bus.addr == rq.opcode_addr + 16'h0002;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch order");
	property p_dummy;
		start && !busy |=> ##12 bus.addr == DUMMY_ADDR && bus.rw;
	endproperty
	a_dummy: assert property (p_dummy) else $error("cycle 4");
	property p_len;
		done |-> cnt == 4 * ncyc(group) + 1;
	endproperty
	a_len: assert property (p_len) else $error("length");
	property p_noacc;
		busy && group inside {GRP_JUMP, GRP_TEST} |-> bus.rw;
	endproperty
	a_noacc: assert property (p_noacc) else $error("write");
	property p_test;
		done && group == GRP_TEST |-> $past(bus.addr) == DUMMY_ADDR;
	endproperty
	a_test: assert property (p_test) else $error("test end");
	property p_ar16;
		done && group == GRP_ARITH16 |-> $past(bus.addr) == DUMMY_ADDR
			&& $past(bus.addr, 5) == $past(bus.addr, 9) + 16'h0001;
	endproperty
	a_ar16: assert property (p_ar16) else $error("arith");
	property p_st16;
		done && group == GRP_STORE16 |-> !$past(bus.rw) && !$past(bus.rw, 5)
			&& $past(bus.addr) == $past(bus.addr, 5) + 16'h0001
			&& $past(bus.dout, 5) == rq.reg16[15:8];
	endproperty
	a_st16: assert property (p_st16) else $error("store16");
	property p_st8;
		done && group == GRP_STORE8 |-> !$past(bus.rw) && $past(bus.rw, 5)
			&& $past(bus.dout) == rq.acc_a && !$past(bus.dout_oe_b);
	endproperty
	a_st8: assert property (p_st8) else $error("store8");
endmodule

bind ycs_sequencer ycs_sequencer_asserts u_chk (.ref_clk(ref_clk),
	.rst_b(rst_b), .start(start), .req(req), .bus_din(bus_din),
	.bus(bus), .busy(busy), .done(done), .prefix_err(prefix_err),
	.group(group), .operand(operand));
`default_nettype wire

// [sim/ycs_mem.sv]
// Memory model on the far side of the sequencer's bus.
// Answers combinationally; stores writes at the clock.
`timescale 1ns/1ps
`default_nettype none
module ycs_mem
	import ycs_pkg::*;
(
	input  wire logic     ref_clk, // Clock
	input  wire ycs_bus_t bus,     // Bus from the sequencer
	output logic [7:0]    bus_din  // Read data
);
	logic [7:0] mem [0:65535];
	logic [7:0] junk = 8'hA5;

	// Dummy reads see a changing pattern; writes land each clock
	always @(posedge ref_clk) begin
		junk <= ~junk + 8'h01;
		if (!bus.rw)
			mem[bus.addr] <= bus.dout;
	end
	assign bus_din = (bus.addr == DUMMY_ADDR) ? junk
		: mem[bus.addr];
endmodule
`default_nettype wire

// [sim/ycs_sequencer_tb.sv]
// Testbench for the indexed-Y bus-cycle sequencer.
// Memory model on the bus; checker bound to the sequencer.
`timescale 1ns/1ps
`default_nettype none
module ycs_sequencer_tb
	import ycs_pkg::*;
;
	logic        ref_clk = 1'b0;
	logic        rst_b   = 1'b0;
	logic        start   = 1'b0;
	ycs_req_t    req     = '0;
	logic [7:0]  bus_din;
	ycs_bus_t    bus;
	logic        busy, done, prefix_err;
	ycs_grp_t    group;
	logic [15:0] operand;
	int          n_fail  = 0;
	int          checks  = 0;

	always #50 ref_clk = ~ref_clk;

	ycs_sequencer DUT (.ref_clk(ref_clk), .rst_b(rst_b), .start(start),
		.req(req), .bus_din(bus_din), .bus(bus), .busy(busy), .done(done),
		.prefix_err(prefix_err), .group(group), .operand(operand));
	ycs_mem M (.ref_clk(ref_clk), .bus(bus), .bus_din(bus_din));

	// ==========================================================
	// Compare, verdict
	task automatic chk(logic [15:0] s, logic [15:0] e);
		checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic report_and_stop();
		if (n_fail == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Run one instruction at 0100 and time it in clocks
	task automatic go(logic [7:0] pre, logic [7:0] op, logic [15:0] iy,
		logic [7:0] off, int n);
		int k;
		M.mem[16'h0100] = pre;
		M.mem[16'h0101] = op;
		M.mem[16'h0102] = off;
		@(posedge ref_clk);
		start <= 1'b1;
		req   <= '{16'h0100, iy, 8'h5A, 16'hBEEF};
		@(posedge ref_clk);
		start <= 1'b0;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
			if (k == 1)
				chk(busy, 1'b1);
		end while (!done && k < 40);
		chk(k, 4 * n + 1);
		chk(busy, 1'b0);
		chk(prefix_err, pre != PREFIX_PAGE);
	endtask

	// ==========================================================
	// Scenarios
	// Wrong first byte is flagged; the jump still runs
	task automatic s_bad_prefix();
		go(8'h00, OP_JUMP, 16'h1000, 8'h10, 4);
	endtask
	// Any other second byte reads one operand byte at EA
	task automatic s_read8();
		M.mem[16'h5003] = 8'h9C;
		go(PREFIX_PAGE, 8'hA6, 16'h5000, 8'h03, 5);
		chk(operand, 16'h009C);
		chk(group, GRP_READ8);
	endtask
	task automatic s_jump();
		go(PREFIX_PAGE, OP_JUMP, 16'h1000, 8'h10, 4);
		chk(group, GRP_JUMP);
	endtask
	task automatic s_test();
		M.mem[16'h1010] = 8'h77;
		go(PREFIX_PAGE, OP_TEST, 16'h1000, 8'h10, 7);
		chk(operand, 16'h0077);
		chk(M.mem[16'h1010], 8'h77);
	endtask
	// Effective address wraps past FFFF
	task automatic s_read16();
		M.mem[16'h0000] = 8'h12;
		M.mem[16'h0001] = 8'h34;
		go(PREFIX_PAGE, OP_LOAD16, 16'hFFF8, 8'h08, 6);
		chk(operand, 16'h1234);
	endtask
	task automatic s_arith();
		M.mem[16'h20FF] = 8'hC3;
		M.mem[16'h2100] = 8'h3C;
		go(PREFIX_PAGE, OP_ADD16, 16'h2000, 8'hFF, 7);
		chk(operand, 16'hC33C);
	endtask
	task automatic s_store16();
		go(PREFIX_PAGE, OP_STORE16, 16'h3000, 8'h80, 6);
		chk(M.mem[16'h3080], 8'hBE);
		chk(M.mem[16'h3081], 8'hEF);
	endtask
	task automatic s_store8();
		M.mem[16'h4002] = 8'h00;
		go(PREFIX_PAGE, OP_STOREA, 16'h4000, 8'h01, 5);
		chk(M.mem[16'h4001], 8'h5A);
		chk(M.mem[16'h4002], 8'h00);
	endtask

	initial begin
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		s_bad_prefix();
		s_jump();
		s_read8();
		s_test();
		s_read16();
		s_arith();
		s_store16();
		s_store8();
		report_and_stop();
	end
	// Watchdog
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire
